// ---- rtl/cpc_top.sv ----
// charger protection control: sense mux, over-voltage and reverse mode
// assumes comparator inputs synchronous to clk_i, strobe register port
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "cpc_defines.svh"

module cpc_top
    import cpc_pkg::*;
#(
    parameter logic [15:0] SLOW_CYC = 16'(`CPC_SLOW_US * `CPC_CLK_MHZ),
    parameter logic [15:0] FAST_CYC = 16'(`CPC_FAST_US * `CPC_CLK_MHZ),
    parameter logic [15:0] LOCK_CYC = 16'(`CPC_LOCK_US * `CPC_CLK_MHZ),
    parameter logic [15:0] DEB_CYC  = 16'(`CPC_DEB_US * `CPC_CLK_MHZ),
    parameter logic [15:0] RAMP_CYC = 16'(`CPC_RAMP_US * `CPC_CLK_MHZ)
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        vbus_overvoltage_i,
    input  wire logic        over_first_thr_i,
    input  wire logic        over_second_thr_i,
    input  wire logic        wrong_direction_i,
    output logic      [1:0]  sense_sel_o,
    output logic             charge_sense_oe_n_o,
    output logic             charge_fet_gate_o,
    output logic             main_supply_fet_gate_o,
    output logic             usb_path_open_o,
    output logic             bp_regulator_en_o,
    output logic             charge_voltage_regulator_en_o,
    output logic             reverse_slow_turn_on_o,
    output logic             irq_o
);

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    function automatic logic [15:0] hold_count(
        input logic        cond,
        input logic [15:0] cnt
    );
        logic [15:0] r;
        r = `CPC_CNT_ZERO;
        if (cond) begin
            r = (cnt == 16'hFFFF) ? cnt : 16'(cnt + 16'h0001);
        end
        return r;
    endfunction

    function automatic logic [15:0] down_count(
        input logic [15:0] cnt
    );
        return (cnt == `CPC_CNT_ZERO) ? cnt : 16'(cnt - 16'h0001);
    endfunction

    // -----------------------------------------------------------
    // state
    // -----------------------------------------------------------
    cpc_state_t s_q;
    cpc_state_t s_d;

    logic       ov_now;
    logic       rev_on;
    logic       chg_reg_on;
    logic [2:0] irq_set;
    logic       slow_trip;
    logic       fast_trip;
    logic       deb_trip;
    logic       wr_pwr;
    logic       wr_clr;

    assign ov_now = vbus_overvoltage_i;
    assign rev_on = (s_q.rev != RV_OFF);
    assign wr_pwr = wr_i && (addr_i == `CPC_OFS_PWR_CTRL);
    assign wr_clr = wr_i && (addr_i == `CPC_OFS_IRQ_CLR);

    // charge regulator runs with charge enable, a nonzero current, no reverse, no ov
    // a set reverse bit already counts as reverse mode, even before ramp
    assign chg_reg_on = s_q.pwr[`CPC_PWR_CHG_EN] && !rev_on && !ov_now
        && !s_q.pwr[`CPC_PWR_REV_EN]
        && (s_q.pwr[`CPC_PWR_CUR_MSB:`CPC_PWR_CUR_LSB] != 4'h0);

    assign slow_trip = (s_q.rev == RV_ON) && over_first_thr_i
        && !over_second_thr_i
        && (s_q.slow_cnt >= 16'(SLOW_CYC - 16'h0001));
    assign fast_trip = (s_q.rev == RV_ON) && over_second_thr_i
        && (s_q.fast_cnt >= 16'(FAST_CYC - 16'h0001));
    assign deb_trip = rev_on && wrong_direction_i
        && (s_q.deb_cnt >= 16'(DEB_CYC - 16'h0001));

    // -----------------------------------------------------------
    // next state
    // -----------------------------------------------------------
    always_comb begin
        s_d = s_q;
        irq_set = `CPC_IRQ_RESET;

        // register writes
        if (wr_pwr) begin
            s_d.pwr = wdata_i[`CPC_PWR_WIDTH-1:0];
            if (s_q.lock_cnt != `CPC_CNT_ZERO) begin
                s_d.pwr[`CPC_PWR_REV_EN] = 1'b0;
            end
        end
        if (wr_i && (addr_i == `CPC_OFS_IRQ_EN)) begin
            s_d.irq_en = wdata_i[`CPC_IRQ_WIDTH-1:0];
        end
        if (wr_clr) begin
            s_d.irq_stat = s_q.irq_stat & ~wdata_i[`CPC_IRQ_WIDTH-1:0];
        end

        // over-voltage
        s_d.ov = ov_now;
        if (ov_now && !s_q.ov) begin
            irq_set[`CPC_IRQ_OV] = 1'b1;
        end
        if (ov_now) begin
            s_d.pwr[`CPC_PWR_CUR_MSB:`CPC_PWR_CUR_LSB] = 4'h0;
        end

        // reverse trip timers
        s_d.slow_cnt = hold_count((s_q.rev == RV_ON) && over_first_thr_i
            && !over_second_thr_i, s_q.slow_cnt);
        s_d.fast_cnt = hold_count((s_q.rev == RV_ON) && over_second_thr_i,
            s_q.fast_cnt);
        s_d.deb_cnt  = hold_count(rev_on && wrong_direction_i,
            s_q.deb_cnt);
        s_d.lock_cnt = down_count(s_q.lock_cnt);
        s_d.ramp_cnt = down_count(s_q.ramp_cnt);

        if (slow_trip || fast_trip) begin
            irq_set[`CPC_IRQ_REV_OC] = 1'b1;
            s_d.pwr[`CPC_PWR_REV_EN] = 1'b0;
        end
        if (deb_trip) begin
            irq_set[`CPC_IRQ_REV_CHG] = 1'b1;
            s_d.pwr[`CPC_PWR_REV_EN] = 1'b0;
            s_d.lock_cnt = LOCK_CYC;
        end

        // reverse path state machine
        case (s_q.rev)
            RV_OFF: begin
                if (s_q.pwr[`CPC_PWR_REV_EN] && !ov_now) begin
                    s_d.rev = RV_RAMP;
                    s_d.ramp_cnt = RAMP_CYC;
                end
            end
            RV_RAMP: begin
                if (!s_q.pwr[`CPC_PWR_REV_EN] || ov_now || deb_trip) begin
                    s_d.rev = RV_OFF;
                end else if (s_q.ramp_cnt == `CPC_CNT_ZERO) begin
                    s_d.rev = RV_ON;
                end
            end
            RV_ON: begin
                if (!s_q.pwr[`CPC_PWR_REV_EN] || ov_now || deb_trip
                    || slow_trip || fast_trip) begin
                    s_d.rev = RV_OFF;
                end
            end
            default: begin
                s_d.rev = RV_OFF;
            end
        endcase

        // sticky flags, set beats clear
        s_d.irq_stat = s_d.irq_stat | irq_set;

        // read data stands for one cycle only
        s_d.rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `CPC_OFS_PWR_CTRL: begin
                    s_d.rdata[`CPC_PWR_WIDTH-1:0] = s_q.pwr;
                end
                `CPC_OFS_STATUS: begin
                    s_d.rdata[`CPC_ST_OV_SNS] = ov_now;
                    s_d.rdata[`CPC_ST_REV_ON] = (s_q.rev == RV_ON);
                    s_d.rdata[`CPC_ST_LOCKED] =
                        (s_q.lock_cnt != `CPC_CNT_ZERO);
                end
                `CPC_OFS_IRQ_STAT: begin
                    s_d.rdata[`CPC_IRQ_WIDTH-1:0] = s_q.irq_stat;
                end
                `CPC_OFS_IRQ_EN: begin
                    s_d.rdata[`CPC_IRQ_WIDTH-1:0] = s_q.irq_en;
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // registers
    // -----------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q.pwr      <= `CPC_PWR_RESET;
            s_q.irq_stat <= `CPC_IRQ_RESET;
            s_q.irq_en   <= `CPC_IRQ_RESET;
            s_q.ov       <= 1'b0;
            s_q.rev      <= RV_OFF;
            s_q.slow_cnt <= `CPC_CNT_ZERO;
            s_q.fast_cnt <= `CPC_CNT_ZERO;
            s_q.deb_cnt  <= `CPC_CNT_ZERO;
            s_q.lock_cnt <= `CPC_CNT_ZERO;
            s_q.ramp_cnt <= `CPC_CNT_ZERO;
            s_q.rdata    <= 32'h0000_0000;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------
    // outputs
    // -----------------------------------------------------------
    always_comb begin
        if (rev_on) begin
            sense_sel_o = SNS_DISCHARGE;
        end else if (chg_reg_on) begin
            sense_sel_o = SNS_CHARGE;
        end else begin
            sense_sel_o = SNS_ID;
        end
    end

    assign rdata_o = s_q.rdata;
    assign charge_sense_oe_n_o = s_q.pwr[`CPC_PWR_MUX_DIS];
    // gate high holds a fet open
    assign charge_fet_gate_o = ov_now || !(rev_on || chg_reg_on);
    assign main_supply_fet_gate_o = ov_now || rev_on;
    assign usb_path_open_o = ov_now;
    assign bp_regulator_en_o = !ov_now && s_q.pwr[`CPC_PWR_DUAL];
    assign charge_voltage_regulator_en_o = chg_reg_on;
    assign reverse_slow_turn_on_o = (s_q.rev == RV_RAMP);
    assign irq_o = |(s_q.irq_stat & s_q.irq_en);

endmodule

// ---- rtl/cpc_defines.svh ----
// constants of the charger protection control block
// assumes a single 20 MHz clock and a plain strobe register port
//
// Operation
// - sense output follows charge, discharge or id
// - mux disable bit floats the sense output
// - over-voltage opens all three protected paths
// - over-voltage flags irq, zeroes current, stops regulator
// - readable live over-voltage sense status bit
// - bp regulator returns after over-voltage; current stays zero, so charge regulator stays off
// - reverse enable turns fets on slowly
// - first-threshold overcurrent over slow window trips
// - second-threshold overcurrent over fast time trips
// - reverse mode keeps charge voltage regulator off
// - wrong-direction current trips and clears reverse bit
// - reverse enable writes ignored for lockout time
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CPC_OFS_PWR_CTRL  8'h04
`define CPC_OFS_STATUS    8'h08
`define CPC_OFS_IRQ_STAT  8'h0C
`define CPC_OFS_IRQ_CLR   8'h10
`define CPC_OFS_IRQ_EN    8'h14

// ---------------------------------------------------------------
// power control fields
// ---------------------------------------------------------------
`define CPC_PWR_CUR_LSB   0
`define CPC_PWR_CUR_MSB   3
`define CPC_PWR_MUX_DIS   4
`define CPC_PWR_CHG_EN    5
`define CPC_PWR_REV_EN    6
`define CPC_PWR_DUAL      7
`define CPC_PWR_WIDTH     8
`define CPC_PWR_RESET     8'h00

// ---------------------------------------------------------------
// status and interrupt bits
// ---------------------------------------------------------------
`define CPC_ST_OV_SNS     0
`define CPC_ST_REV_ON     1
`define CPC_ST_LOCKED     2
`define CPC_IRQ_OV        0
`define CPC_IRQ_REV_OC    1
`define CPC_IRQ_REV_CHG   2
`define CPC_IRQ_WIDTH     3
`define CPC_IRQ_RESET     3'h0

// ---------------------------------------------------------------
// timing, microseconds and clock rate
// ---------------------------------------------------------------
`define CPC_CLK_MHZ       20
`define CPC_SLOW_US       1000
`define CPC_FAST_US       100
`define CPC_LOCK_US       1000
`define CPC_DEB_US        100
`define CPC_RAMP_US       50
`define CPC_CNT_WIDTH     16
`define CPC_CNT_ZERO      16'h0000

`endif

// ---- rtl/cpc_pkg.sv ----
// types of the charger protection control block
// assumes cpc_defines.svh for register and counter widths; state and sense encodings are local
`include "cpc_defines.svh"

package cpc_pkg;

    // -----------------------------------------------------------
    // reverse path states
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        RV_OFF  = 3'b001,
        RV_RAMP = 3'b010,
        RV_ON   = 3'b100
    } cpc_rev_t;

    // -----------------------------------------------------------
    // sense output selection
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        SNS_ID        = 2'h0,
        SNS_CHARGE    = 2'h1,
        SNS_DISCHARGE = 2'h2
    } cpc_sns_t;

    // -----------------------------------------------------------
    // whole state of the block
    // -----------------------------------------------------------
    typedef struct packed {
        logic [`CPC_PWR_WIDTH-1:0] pwr;
        logic [`CPC_IRQ_WIDTH-1:0] irq_stat;
        logic [`CPC_IRQ_WIDTH-1:0] irq_en;
        logic                      ov;
        cpc_rev_t                  rev;
        logic [`CPC_CNT_WIDTH-1:0] slow_cnt;
        logic [`CPC_CNT_WIDTH-1:0] fast_cnt;
        logic [`CPC_CNT_WIDTH-1:0] deb_cnt;
        logic [`CPC_CNT_WIDTH-1:0] lock_cnt;
        logic [`CPC_CNT_WIDTH-1:0] ramp_cnt;
        logic [31:0]               rdata;
    } cpc_state_t;

endpackage

// ---- tb/cpc_load_model.sv ----
// far side model: charge path fets with a load on vbus
// assumes gate outputs of cpc_top; high gate means fet open
`timescale 1ns/1ps
module cpc_load_model (
    input  wire logic       gate_chg_i,
    input  wire logic       gate_main_i,
    input  wire logic [1:0] load_i,
    input  wire logic       back_i,
    output logic            thr1_o,
    output logic            thr2_o,
    output logic            wrong_o
);
    // ----------------------------------------------------------
    // current flows only while the reverse path conducts
    // ----------------------------------------------------------
    logic path;
    assign path    = !gate_chg_i && gate_main_i;
    assign thr1_o  = path && (load_i != 2'h0);
    assign thr2_o  = path && (load_i == 2'h2);
    assign wrong_o = path && back_i;
endmodule

// ---- tb/cpc_monitor.sv ----
// port checker of the charger protection control block
// assumes binding onto cpc_top, one clock domain
`timescale 1ns/1ps
module cpc_monitor
    import cpc_pkg::*;
#(
    parameter logic [15:0] FAST_CYC = 16'h07D0,
    parameter logic [15:0] RAMP_CYC = 16'h03E8
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        vbus_overvoltage_i,
    input wire logic        over_second_thr_i,
    input wire logic [1:0]  sense_sel_o,
    input wire logic        charge_sense_oe_n_o,
    input wire logic        charge_fet_gate_o,
    input wire logic        main_supply_fet_gate_o,
    input wire logic        usb_path_open_o,
    input wire logic        bp_regulator_en_o,
    input wire logic        charge_voltage_regulator_en_o,
    input wire logic        reverse_slow_turn_on_o,
    input wire logic        irq_o
);
    // ----------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------
    logic [15:0] ramp_q;
    logic [15:0] fast_q;
    logic        rev_on;
    assign rev_on = main_supply_fet_gate_o && !vbus_overvoltage_i
                    && !reverse_slow_turn_on_o;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !reverse_slow_turn_on_o) ramp_q <= 16'h0000;
        else if (ce_i) ramp_q <= ramp_q + 16'h0001;
        if (sys_rst_i || !(rev_on && over_second_thr_i)) fast_q <= 16'h0000;
        else if (ce_i) fast_q <= fast_q + 16'h0001;
    end

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ov_paths_open_a: assert property (vbus_overvoltage_i |->
        charge_fet_gate_o && main_supply_fet_gate_o && usb_path_open_o)
        else $error("paths not opened on over-voltage");
    ov_regs_off_a: assert property (vbus_overvoltage_i |->
        !bp_regulator_en_o && !charge_voltage_regulator_en_o)
        else $error("regulators on during over-voltage");
    rev_vreg_off_a: assert property (main_supply_fet_gate_o |->
        !charge_voltage_regulator_en_o)
        else $error("charge regulator on in reverse mode");
    ramp_length_a: assert property ($fell(reverse_slow_turn_on_o)
        && main_supply_fet_gate_o && !vbus_overvoltage_i
        |-> ramp_q == RAMP_CYC + 16'h0001)
        else $error("slow turn-on length wrong");
    charge_sense_a: assert property (charge_voltage_regulator_en_o
        |-> sense_sel_o == SNS_CHARGE)
        else $error("sense select not charge");
    mux_float_a: assert property (wr_i && ce_i && addr_i == 8'h04
        |=> charge_sense_oe_n_o == $past(wdata_i[4]))
        else $error("sense drive enable wrong");
    fast_trip_a: assert property (fast_q == FAST_CYC
        |-> !main_supply_fet_gate_o)
        else $error("fast trip late");
    irq_latch_a: assert property (irq_o && !wr_i |=> irq_o)
        else $error("interrupt dropped without write");
    cover property ($rose(irq_o));
    cover property ($fell(reverse_slow_turn_on_o));
    cover property (fast_q == FAST_CYC);
endmodule

bind cpc_top cpc_monitor #(.FAST_CYC(FAST_CYC), .RAMP_CYC(RAMP_CYC)) mon (
    .clk_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i, .wr_i,
    .vbus_overvoltage_i, .over_second_thr_i, .sense_sel_o,
    .charge_sense_oe_n_o, .charge_fet_gate_o, .main_supply_fet_gate_o,
    .usb_path_open_o, .bp_regulator_en_o,
    .charge_voltage_regulator_en_o, .reverse_slow_turn_on_o, .irq_o);

// ---- tb/charger_protection_control_tb.sv ----
// bench of the charger protection control block
// assumes cpc_top, cpc_load_model and the bound checker
`timescale 1ns/1ps
module charger_protection_control_tb
    import cpc_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        vbus_overvoltage_i = 1'b0;
    logic [1:0]  load = 2'h0;
    logic        back = 1'b0;
    logic [31:0] rdata_o;
    logic [1:0]  sense_sel_o;
    logic        over_first_thr_i, over_second_thr_i, wrong_direction_i;
    logic        charge_sense_oe_n_o, charge_fet_gate_o, irq_o;
    logic        main_supply_fet_gate_o, usb_path_open_o;
    logic        bp_regulator_en_o, charge_voltage_regulator_en_o;
    logic        reverse_slow_turn_on_o;
    logic [8:0]  f;
    int          n_mismatch = 0;
    int          n_compared = 0;
    assign f = {sense_sel_o, charge_sense_oe_n_o,
                charge_voltage_regulator_en_o, bp_regulator_en_o,
                usb_path_open_o, main_supply_fet_gate_o,
                charge_fet_gate_o, irq_o};
    always #25 clk_i = ~clk_i;

    cpc_top #(
        .SLOW_CYC(16'h0014),
        .FAST_CYC(16'h0005),
        .LOCK_CYC(16'h001E),
        .DEB_CYC (16'h0005),
        .RAMP_CYC(16'h0004)
    ) dut (
        .clk_i                        (clk_i),
        .sys_rst_i                    (sys_rst_i),
        .ce_i                         (ce_i),
        .addr_i                       (addr_i),
        .wdata_i                      (wdata_i),
        .wr_i                         (wr_i),
        .rd_i                         (rd_i),
        .rdata_o                      (rdata_o),
        .vbus_overvoltage_i           (vbus_overvoltage_i),
        .over_first_thr_i             (over_first_thr_i),
        .over_second_thr_i            (over_second_thr_i),
        .wrong_direction_i            (wrong_direction_i),
        .sense_sel_o                  (sense_sel_o),
        .charge_sense_oe_n_o          (charge_sense_oe_n_o),
        .charge_fet_gate_o            (charge_fet_gate_o),
        .main_supply_fet_gate_o       (main_supply_fet_gate_o),
        .usb_path_open_o              (usb_path_open_o),
        .bp_regulator_en_o            (bp_regulator_en_o),
        .charge_voltage_regulator_en_o(charge_voltage_regulator_en_o),
        .reverse_slow_turn_on_o       (reverse_slow_turn_on_o),
        .irq_o                        (irq_o)
    );
    cpc_load_model model (.gate_chg_i(charge_fet_gate_o),
        .gate_main_i(main_supply_fet_gate_o), .load_i(load), .back_i(back),
        .thr1_o(over_first_thr_i), .thr2_o(over_second_thr_i),
        .wrong_o(wrong_direction_i));

    // ----------------------------------------------------------
    // access and check tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h0);
        chk(32'(f), 32'h0002);
        wr(8'h04, 32'h25);
        chk(32'(f), 32'h00A0);
        wr(8'h04, 32'h35);
        chk(32'(f), 32'h00E0);
        wr(8'h14, 32'h7);
        rd(8'h14, 32'h7);
        wr(8'h04, 32'hAA);
        chk(32'(f), 32'h00B0);
        @(posedge clk_i) vbus_overvoltage_i <= 1'b1;
        tick(1);
        chk(32'(f[6:0]), 32'h0F);
        rd(8'h08, 32'h1);
        rd(8'h0C, 32'h1);
        rd(8'h04, 32'hA0);
        @(posedge clk_i) vbus_overvoltage_i <= 1'b0;
        tick(1);
        chk(32'(f[6:0]), 32'h13);
        rd(8'h04, 32'hA0);
        rd(8'h08, 32'h0);
        wr(8'h14, 32'h0);
        chk(32'(irq_o), 32'h0);
        wr(8'h14, 32'h7);
        chk(32'(irq_o), 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h0C, 32'h0);
        wr(8'h04, 32'h40);
        tick(1);
        chk(32'(reverse_slow_turn_on_o), 32'h1);
        tick(7);
        chk(32'(f), 32'h0104);
        rd(8'h08, 32'h2);
        @(posedge clk_i) load <= 2'h2;
        tick(8);
        chk(32'(f), 32'h0003);
        rd(8'h0C, 32'h2);
        rd(8'h04, 32'h0);
        load <= 2'h0;
        wr(8'h10, 32'h2);
        wr(8'h04, 32'h40);
        tick(8);
        @(posedge clk_i) load <= 2'h1;
        tick(15);
        chk(32'(main_supply_fet_gate_o), 32'h1);
        tick(10);
        chk(32'(f), 32'h0003);
        rd(8'h0C, 32'h2);
        load <= 2'h0;
        wr(8'h10, 32'h2);
        wr(8'h04, 32'h40);
        tick(8);
        @(posedge clk_i) back <= 1'b1;
        tick(8);
        rd(8'h0C, 32'h4);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h4);
        wr(8'h04, 32'h40);
        rd(8'h04, 32'h0);
        chk(32'(main_supply_fet_gate_o), 32'h0);
        back <= 1'b0;
        tick(35);
        wr(8'h04, 32'h40);
        rd(8'h04, 32'h40);
        wr(8'h04, 32'h0);
        wr(8'h10, 32'h4);
        @(posedge clk_i) ce_i <= 1'b0;
        wr(8'h04, 32'h25);
        @(posedge clk_i) ce_i <= 1'b1;
        rd(8'h04, 32'h0);
        print_verdict();
    end
endmodule
